// *** inc/ruc_pkg.sv ***
/*
 * constants, register layout, timing counts and state codes of the
 * once-per-second update sequencer of a real-time clock.
 * assumes a 25 MHz system clock; all files reference names as ruc_pkg::name.
 */
// What this block does
// - update once per second only when allowed
// - set bit aborts and blocks updates
// - increment seconds, carry up to year
// - alarm when all three positions match
// - update lasts 248 or 1984 us
// - time bytes hidden from bus during update
// - progress flag rises 244 us before update
// - update-ended flag after each completed update
// - periodic flag brackets progress flag high time
// - standby gate blocks bus inputs
// - first update half second after set cleared
package ruc_pkg;

	// ==========================================================
	// timing
	// ==========================================================
	localparam int CLK_HZ          = 25_000_000;   // system clock rate
	localparam int CLK_MHZ         = CLK_HZ / 1_000_000;
	localparam int PRE_UPDATE_US   = 244;          // pre_update_delay
	localparam int UPDATE_FAST_US  = 248;          // update_duration, fast bases
	localparam int UPDATE_SLOW_US  = 1984;         // update_duration, 32.768 kHz
	localparam int SECOND_MS       = 1000;         // update period
	localparam int FIRST_UPDATE_MS = 500;          // delay after set is cleared
	localparam int PRE_UPDATE_CYC  = PRE_UPDATE_US * CLK_MHZ;
	localparam int UPDATE_FAST_CYC = UPDATE_FAST_US * CLK_MHZ;
	localparam int UPDATE_SLOW_CYC = UPDATE_SLOW_US * CLK_MHZ;
	localparam int SECOND_CYC      = SECOND_MS * (CLK_HZ / 1000);
	localparam int FIRST_UPD_CYC   = FIRST_UPDATE_MS * (CLK_HZ / 1000);

	// ==========================================================
	// register byte offsets
	// ==========================================================
	localparam logic [5:0] OFS_SEC      = 6'h00;
	localparam logic [5:0] OFS_SEC_ALM  = 6'h04;
	localparam logic [5:0] OFS_MIN      = 6'h08;
	localparam logic [5:0] OFS_MIN_ALM  = 6'h0C;
	localparam logic [5:0] OFS_HOUR     = 6'h10;
	localparam logic [5:0] OFS_HOUR_ALM = 6'h14;
	localparam logic [5:0] OFS_DOW      = 6'h18;
	localparam logic [5:0] OFS_DATE     = 6'h1C;
	localparam logic [5:0] OFS_MONTH    = 6'h20;
	localparam logic [5:0] OFS_YEAR     = 6'h24;
	localparam logic [5:0] OFS_CTRL_A   = 6'h28;
	localparam logic [5:0] OFS_CTRL_B   = 6'h2C;
	localparam logic [5:0] OFS_CTRL_C   = 6'h30;

	// ==========================================================
	// field positions
	// ==========================================================
	localparam int CA_UIP_BIT = 7;      // update_in_progress_flag
	localparam int CA_DV_LSB  = 4;      // divider_select_bit0..2 in [6:4]
	localparam int CB_SET_BIT = 7;      // set control bit
	localparam int CB_PIE_BIT = 6;      // periodic enable
	localparam int CB_AIE_BIT = 5;      // alarm enable
	localparam int CB_UIE_BIT = 4;      // update-ended enable

	// ==========================================================
	// divider codes, reset values, limits
	// ==========================================================
	localparam logic [2:0] DV_4M       = 3'h0;
	localparam logic [2:0] DV_1M       = 3'h1;
	localparam logic [2:0] DV_32K      = 3'h2;
	localparam logic [1:0] DV_CLEAR_HI = 2'h3;  // both upper bits hold divider clear
	localparam logic [6:0] CTRL_A_RST  = 7'h00;
	localparam logic [3:0] CTRL_B_RST  = 4'h0;
	localparam logic [7:0] TIME_ZERO   = 8'h00;
	localparam logic [7:0] TIME_ONE    = 8'h01;
	localparam logic [7:0] SEC_MAX     = 8'h3B;
	localparam logic [7:0] HOUR_MAX    = 8'h17;
	localparam logic [7:0] DOW_MAX     = 8'h07;
	localparam logic [7:0] MONTH_MAX   = 8'h0C;
	localparam logic [7:0] YEAR_MAX    = 8'h63;
	localparam logic [1:0] DONT_CARE   = 2'h3;  // top two alarm bits

	// ==========================================================
	// sequencer states
	// ==========================================================
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_PRE = 3'b010,
		ST_UPD = 3'b100
	} ruc_state_t;

endpackage

// *** hw/ruc_unit_counter.sv ***
/*
 * one time unit of the calendar chain: steps a value between a floor and
 * a ceiling and flags the carry into the next unit.
 * assumes the caller loads the result only on an update.
 */
`timescale 1ns/1ps
module ruc_unit_counter
(
	input  wire logic [7:0] value,
	input  wire logic [7:0] floorVal,
	input  wire logic [7:0] ceilVal,
	input  wire logic       step,
	output logic      [7:0] nextVal,
	output logic            carry
);

	// ==========================================================
	// step and wrap
	// ==========================================================
	// values above the ceiling also wrap, so a bad load cannot run away
	always_comb
	begin
		carry   = step && (value >= ceilVal);
		nextVal = value;
		if (carry)
		begin
			nextVal = floorVal;
		end
		else if (step)
		begin
			nextVal = value + 8'h01;
		end
	end

endmodule

// *** hw/ruc_update_ctrl.sv ***
/*
 * update sequencer of the clock: second prescaler, pre-update flag,
 * timed update window, calendar chain, alarm compare, status flags and an
 * Avalon-MM slave with waitrequest for the register bytes.
 * assumes a 25 MHz clock and bus inputs synchronous to it.
 */
`timescale 1ns/1ps
module ruc_update_ctrl
#(
	parameter int SEC_CYC  = ruc_pkg::SECOND_CYC,
	parameter int HALF_CYC = ruc_pkg::FIRST_UPD_CYC,
	parameter int BUC_CYC  = ruc_pkg::PRE_UPDATE_CYC,
	parameter int UCF_CYC  = ruc_pkg::UPDATE_FAST_CYC,
	parameter int UCS_CYC  = ruc_pkg::UPDATE_SLOW_CYC
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	input  wire logic        busInputGate,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	output logic             updateInProgress,
	output logic             updateActive,
	output logic             irqRequest
);

	// ==========================================================
	// widths and fixed points
	// ==========================================================
	localparam int PW = $clog2(SEC_CYC + 1);
	localparam int UW = $clog2(UCS_CYC + UCF_CYC + 1);
	localparam logic [PW-1:0] SEC_LAST  = PW'(SEC_CYC - 1);
	localparam logic [PW-1:0] PRE_POINT = PW'(SEC_CYC - 1 - BUC_CYC);
	localparam logic [PW-1:0] HALF_PT   = PW'(HALF_CYC);
	localparam logic [UW-1:0] UCF_LAST  = UW'(UCF_CYC - 1);
	localparam logic [UW-1:0] UCS_LAST  = UW'(UCS_CYC - 1);

	// ==========================================================
	// state
	// ==========================================================
	logic [7:0]         timeR [0:6];   // sec, min, hour, dow, date, month, year
	logic [7:0]         alarmR [0:2];  // sec, min, hour alarm bytes
	logic [6:0]         ctrlA_r;       // divider select [6:4], rate [3:0]
	logic [3:0]         ctrlB_r;       // set, periodic, alarm, update enables
	logic [2:0]         flag_r;        // periodic, alarm, update-ended flags
	logic [2:0]         flag_nxt;
	logic [PW-1:0]      presc_r;       // position inside the second
	logic [PW-1:0]      perCnt_r;      // periodic interval counter
	logic [UW-1:0]      updCnt_r;      // cycles spent in the update window
	ruc_pkg::ruc_state_t state_r;
	logic [7:0]         rdByte;        // read mux result
	logic [7:0]         nextV [0:6];   // stepped calendar values
	logic [7:0]         floorV [0:6];
	logic [7:0]         ceilV [0:6];
	logic [6:0]         stepV;
	logic [6:0]         carryV;

	// ==========================================================
	// decoded controls
	// ==========================================================
	logic [2:0] dvSel;
	logic [3:0] rateSel;
	logic       setBit;
	logic       divClear;
	logic       tbValid;
	logic       holdSeq;
	logic [UW-1:0] ucLast;
	assign dvSel    = ctrlA_r[6:ruc_pkg::CA_DV_LSB];
	assign rateSel  = ctrlA_r[3:0];
	assign setBit   = ctrlB_r[3];
	assign divClear = (dvSel[2:1] == ruc_pkg::DV_CLEAR_HI);
	// only the three documented bases run; other codes stop the chain
	assign tbValid  = (dvSel == ruc_pkg::DV_4M) || (dvSel == ruc_pkg::DV_1M)
		|| (dvSel == ruc_pkg::DV_32K);
	assign holdSeq  = setBit || divClear;
	assign ucLast   = (dvSel == ruc_pkg::DV_32K) ? UCS_LAST : UCF_LAST;

	// ==========================================================
	// bus handshake
	// ==========================================================
	logic busReq;
	logic capture;
	logic wrEn;
	logic isTimeAddr;
	logic rdClrC;
	logic [7:0] wrByte;
	assign busReq     = avs_read || avs_write;
	assign capture    = busReq && avs_waitrequest;
	assign wrEn       = avs_write && !avs_waitrequest && avs_byteenable[0] && !busInputGate;
	assign isTimeAddr = (avs_address < ruc_pkg::OFS_CTRL_A);
	assign rdClrC     = capture && avs_read && !busInputGate
		&& (avs_address == ruc_pkg::OFS_CTRL_C);
	assign wrByte     = avs_writedata[7:0];

	// waitrequest drops for exactly one cycle per request
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !capture;
	end

	// read mux; unmapped offsets read as zero
	always_comb
	begin
		rdByte = 8'h00;
		unique case (avs_address)
			ruc_pkg::OFS_SEC:      rdByte = timeR[0];
			ruc_pkg::OFS_SEC_ALM:  rdByte = alarmR[0];
			ruc_pkg::OFS_MIN:      rdByte = timeR[1];
			ruc_pkg::OFS_MIN_ALM:  rdByte = alarmR[1];
			ruc_pkg::OFS_HOUR:     rdByte = timeR[2];
			ruc_pkg::OFS_HOUR_ALM: rdByte = alarmR[2];
			ruc_pkg::OFS_DOW:      rdByte = timeR[3];
			ruc_pkg::OFS_DATE:     rdByte = timeR[4];
			ruc_pkg::OFS_MONTH:    rdByte = timeR[5];
			ruc_pkg::OFS_YEAR:     rdByte = timeR[6];
			ruc_pkg::OFS_CTRL_A:   rdByte = {updateInProgress, ctrlA_r};
			ruc_pkg::OFS_CTRL_B:   rdByte = {ctrlB_r, 4'h0};
			ruc_pkg::OFS_CTRL_C:   rdByte = {irqRequest, flag_r, 4'h0};
			default:               rdByte = 8'h00;
		endcase
		if (busInputGate || (isTimeAddr && updateActive))
			rdByte = 8'h00;
	end

	// read data captured together with the waitrequest drop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			avs_readdata <= 32'h0000_0000;
		else if (capture && avs_read)
			avs_readdata <= {24'h00_0000, rdByte};
	end

	// ==========================================================
	// control registers
	// ==========================================================
	// the progress bit of control A is read-only
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ctrlA_r <= ruc_pkg::CTRL_A_RST;
			ctrlB_r <= ruc_pkg::CTRL_B_RST;
		end
		else if (wrEn && (avs_address == ruc_pkg::OFS_CTRL_A))
			ctrlA_r <= wrByte[6:0];
		else if (wrEn && (avs_address == ruc_pkg::OFS_CTRL_B))
			ctrlB_r <= wrByte[7:4];
	end

	// ==========================================================
	// second prescaler
	// ==========================================================
	// restart at half second
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			presc_r <= HALF_PT;
		else if (holdSeq)
			presc_r <= HALF_PT;
		else if (tbValid)
			presc_r <= (presc_r == SEC_LAST) ? '0 : presc_r + 1'b1;
	end

	logic preMark;
	logic updMark;
	logic uipRise;
	logic updStart;
	logic updEnd;
	assign preMark  = tbValid && !holdSeq && (presc_r == PRE_POINT);
	assign updMark  = tbValid && !holdSeq && (presc_r == SEC_LAST);
	assign uipRise  = (state_r == ruc_pkg::ST_RUN) && preMark;
	assign updStart = (state_r == ruc_pkg::ST_PRE) && updMark;
	assign updEnd   = (state_r == ruc_pkg::ST_UPD) && tbValid && !holdSeq
		&& (updCnt_r == ucLast);

	// ==========================================================
	// update sequencer
	// ==========================================================
	// run -> pre (flag up) -> update window -> run
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r          <= ruc_pkg::ST_RUN;
			updateInProgress <= 1'b0;
			updateActive     <= 1'b0;
			updCnt_r         <= '0;
		end
		else if (holdSeq || !tbValid)
		begin
			state_r          <= ruc_pkg::ST_RUN;
			updateInProgress <= 1'b0;
			updateActive     <= 1'b0;
			updCnt_r         <= '0;
		end
		else
		begin
			unique case (state_r)
				ruc_pkg::ST_RUN:
					if (preMark)
					begin
						state_r          <= ruc_pkg::ST_PRE;
						updateInProgress <= 1'b1;
					end
				ruc_pkg::ST_PRE:
					if (updMark)
					begin
						state_r      <= ruc_pkg::ST_UPD;
						updateActive <= 1'b1;
						updCnt_r     <= '0;
					end
				ruc_pkg::ST_UPD:
					if (updEnd)
					begin
						state_r          <= ruc_pkg::ST_RUN;
						updateInProgress <= 1'b0;
						updateActive     <= 1'b0;
					end
					else
						updCnt_r <= updCnt_r + 1'b1;
			endcase
		end
	end

	// ==========================================================
	// calendar chain
	// ==========================================================
	// days in the current month; every fourth year is a leap year
	function automatic logic [7:0] monthDays(input logic [7:0] mon, input logic [7:0] yr);
		logic [7:0] d;
		d = 8'h1F;
		if (mon == 8'h02)
			d = (yr[1:0] == 2'b00) ? 8'h1D : 8'h1C;
		else if ((mon == 8'h04) || (mon == 8'h06) || (mon == 8'h09) || (mon == 8'h0B))
			d = 8'h1E;
		return d;
	endfunction

	always_comb
	begin
		floorV = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
		ceilV  = '{ruc_pkg::SEC_MAX, ruc_pkg::SEC_MAX, ruc_pkg::HOUR_MAX, ruc_pkg::DOW_MAX,
			monthDays(timeR[5], timeR[6]), ruc_pkg::MONTH_MAX, ruc_pkg::YEAR_MAX};
		// day of week and date both follow the hour carry
		stepV  = {carryV[5], carryV[4], carryV[2], carryV[2], carryV[1], carryV[0], 1'b1};
	end

	genvar gi;
	generate
		for (gi = 0; gi < 7; gi++)
		begin : gUnit
			ruc_unit_counter uCnt
			(
				.value    (timeR[gi]),
				.floorVal (floorV[gi]),
				.ceilVal  (ceilV[gi]),
				.step     (stepV[gi]),
				.nextVal  (nextV[gi]),
				.carry    (carryV[gi])
			);
		end
	endgenerate

	// time bytes: stepped on update start, writable outside the window
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			timeR <= '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
			alarmR <= '{8'h00, 8'h00, 8'h00};
		end
		else if (updStart)
			timeR <= nextV;
		else if (wrEn && !updateActive)
		begin
			unique case (avs_address)
				ruc_pkg::OFS_SEC:      timeR[0]  <= wrByte;
				ruc_pkg::OFS_SEC_ALM:  alarmR[0] <= wrByte;
				ruc_pkg::OFS_MIN:      timeR[1]  <= wrByte;
				ruc_pkg::OFS_MIN_ALM:  alarmR[1] <= wrByte;
				ruc_pkg::OFS_HOUR:     timeR[2]  <= wrByte;
				ruc_pkg::OFS_HOUR_ALM: alarmR[2] <= wrByte;
				ruc_pkg::OFS_DOW:      timeR[3]  <= wrByte;
				ruc_pkg::OFS_DATE:     timeR[4]  <= wrByte;
				ruc_pkg::OFS_MONTH:    timeR[5]  <= wrByte;
				ruc_pkg::OFS_YEAR:     timeR[6]  <= wrByte;
				default:               ;
			endcase
		end
	end

	// ==========================================================
	// alarm compare
	// ==========================================================
	logic [2:0] almMatch;
	logic       alarmHit;
	always_comb
	begin
		for (int i = 0; i < 3; i++)
			almMatch[i] = (alarmR[i] == timeR[i])
				|| (alarmR[i][7:6] == ruc_pkg::DONT_CARE);
	end
	assign alarmHit = &almMatch;

	// ==========================================================
	// periodic interval
	// ==========================================================
	logic [PW-1:0] perLast;
	logic          rateOn;
	logic          pfSet;
	assign rateOn  = (rateSel != 4'h0);
	assign perLast = PW'((SEC_CYC >> (5'd16 - {1'b0, rateSel})) - 1);
	assign pfSet   = rateOn && (uipRise || (perCnt_r == perLast));

	// restarting at the flag rise keeps the high interval between two ticks
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			perCnt_r <= '0;
		else if (uipRise || !rateOn || (perCnt_r == perLast))
			perCnt_r <= '0;
		else
			perCnt_r <= perCnt_r + 1'b1;
	end

	// ==========================================================
	// flags and interrupt request
	// ==========================================================
	// periodic, alarm and update-ended flags
	always_comb
	begin
		flag_nxt = flag_r & ~{3{rdClrC}};
		flag_nxt = flag_nxt | {pfSet, updEnd && alarmHit, updEnd};
	end

	// a set arriving with the clearing read still wins
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			flag_r     <= 3'h0;
			irqRequest <= 1'b0;
		end
		else
		begin
			flag_r     <= flag_nxt;
			irqRequest <= |(flag_nxt & ctrlB_r[2:0]);
		end
	end

	// ==========================================================
	// checks
	// ==========================================================
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic [PW-1:0] leadCnt;
	logic [UW-1:0] actLen;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			leadCnt <= '0;
			actLen  <= '0;
		end
		else
		begin
			leadCnt <= (state_r == ruc_pkg::ST_PRE) ? leadCnt + 1'b1 : '0;
			actLen  <= updateActive ? actLen + 1'b1 : '0;
		end
	end

	sequence sSetWrite;
		wrEn && (avs_address == ruc_pkg::OFS_CTRL_B) && wrByte[ruc_pkg::CB_SET_BIT];
	endsequence
	sequence sNormalEnd;
		updEnd ##1 !updateActive;
	endsequence

	chk_set_aborts: assert property (sSetWrite |-> ##2 (!updateActive && !updateInProgress))
		else $error("update still running after set");
	// no update held
	// software may load the seconds byte while held, so that write is left out
	chk_hold_no_update: assert property (holdSeq
		&& !(wrEn && (avs_address == ruc_pkg::OFS_SEC)) |=> $stable(timeR[0]))
		else $error("seconds moved while held");
	chk_uip_lead: assert property (updStart |-> (leadCnt == PW'(BUC_CYC - 1)))
		else $error("pre-update delay wrong");
	chk_update_length: assert property (sNormalEnd |-> ($past(actLen, 1) == ucLast))
		else $error("update window length wrong");
	chk_uf_after_end: assert property (sNormalEnd |-> flag_r[0])
		else $error("update-ended flag missing");
	chk_hidden_read: assert property (capture && avs_read && isTimeAddr && updateActive
		|=> (avs_readdata == 32'h0000_0000))
		else $error("time byte visible during update");
	chk_seconds_step: assert property (updStart && (timeR[0] < ruc_pkg::SEC_MAX)
		|=> (timeR[0] == $past(timeR[0]) + 8'h01))
		else $error("seconds did not step");
	chk_gate_write: assert property (avs_write && busInputGate && !updStart
		|=> $stable(ctrlB_r) && $stable(timeR[0]))
		else $error("gated write changed state");
	chk_alarm_flag: assert property (updEnd && alarmHit |=> flag_r[1])
		else $error("alarm flag missing");
	chk_first_half: assert property ($fell(setBit) && !divClear |-> (presc_r == HALF_PT))
		else $error("prescaler not at half second");
	chk_pf_at_rise: assert property (uipRise && rateOn |=> flag_r[2] && updateInProgress)
		else $error("periodic flag not set at rise");

endmodule

// *** tb/ruc_cpu_model.sv ***
/* processor side of the clock: an avalon-mm master with read and write tasks.
   assumes the slave answers each request with waitrequest low for one clock. */
`timescale 1ns/1ps
module ruc_cpu_model
(
	input  wire logic        clk,
	input  wire logic        waitReq,
	input  wire logic [31:0] rdData,
	output logic      [5:0]  addr,
	output logic             rdEn,
	output logic             wrEn,
	output logic      [31:0] wrData,
	output logic      [3:0]  byteEn
);
	// ==========================================================
	// bus cycles
	// ==========================================================
	// idle bus at time zero; only byte lane 0 carries a register
	initial
	begin
		addr = 6'h00;
		rdEn = 1'b0;
		wrEn = 1'b0;
		wrData = 32'h0000_0000;
		byteEn = 4'h1;
	end
	// write: request held until waitrequest is sampled low
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wrData <= {24'h00_0000, d};
		wrEn <= 1'b1;
		do
			@(posedge clk);
		while (waitReq !== 1'b0);
		wrEn <= 1'b0;
	endtask
	// read: data taken at the same edge as waitrequest low
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rdEn <= 1'b1;
		do
			@(posedge clk);
		while (waitReq !== 1'b0);
		d = rdData;
		rdEn <= 1'b0;
	endtask
endmodule

// *** tb/rtc_update_cycle_control_tb.sv ***
/* self-checking bench of the update sequencer, with shortened counts.
   assumes the processor model drives the register bus. */
`timescale 1ns/1ps
module rtc_update_cycle_control_tb;
	localparam int SEC = 4000;
	localparam int HALF = 2000;
	localparam int BUC = 61;
	localparam int UCF = 62;
	localparam int UCS = 496;
	localparam int LIMIT = 40000;  // cycle ceiling of the whole run
	logic        clk;
	logic        rst;
	logic        gate;
	logic        update_in_progress_flag;
	logic        act;
	logic        irq;
	logic [5:0]  addr;
	logic        rdEn;
	logic        wrEn;
	logic        waitReq;
	logic [31:0] wrData;
	logic [31:0] rdData;
	logic [3:0]  byteEn;
	logic [31:0] v;
	int          n_errors = 0;
	int          checks_done = 0;
	int          cyc = 0;
	ruc_update_ctrl #(.SEC_CYC(SEC), .HALF_CYC(HALF), .BUC_CYC(BUC), .UCF_CYC(UCF),
		.UCS_CYC(UCS)) i_ruc_update_ctrl (.clk(clk), .rst(rst), .avs_address(addr),
		.avs_read(rdEn), .avs_write(wrEn), .avs_writedata(wrData),
		.avs_byteenable(byteEn), .busInputGate(gate), .avs_readdata(rdData),
		.avs_waitrequest(waitReq), .updateInProgress(update_in_progress_flag), .updateActive(act),
		.irqRequest(irq));
	ruc_cpu_model i_ruc_cpu_model (.clk(clk), .waitReq(waitReq), .rdData(rdData),
		.addr(addr), .rdEn(rdEn), .wrEn(wrEn), .wrData(wrData), .byteEn(byteEn));
	// ==========================================================
	// clock, hang guard, compare
	// ==========================================================
	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			n_errors++;
			results();
		end
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rdChk(input logic [5:0] a, input logic [7:0] e, input string nm);
		i_ruc_cpu_model.rd(a, v);
		chk(nm, {24'h00_0000, e}, v);
	endtask
	// one update: pre-update delay, window width, flag fall together
	task automatic meas(input int uc);
		int n;
		n = 0;
		while (update_in_progress_flag !== 1'b1)
			@(posedge clk);
		while (act !== 1'b1)
		begin
			@(posedge clk);
			n++;
		end
		chk("preDelay", 32'(BUC), 32'(n));
		n = 0;
		while (act === 1'b1)
		begin
			@(posedge clk);
			n++;
		end
		chk("updWidth", 32'(uc), 32'(n));
		chk("uipFall", 32'h0000_0000, {31'h0, update_in_progress_flag});
	endtask
	// ==========================================================
	// scenarios
	// ==========================================================
	task automatic tFirst();
		rdChk(ruc_pkg::OFS_DOW, 8'h01, "dowRst");
		meas(UCF);
		rdChk(ruc_pkg::OFS_SEC, 8'h01, "secStep");
	endtask
	// hidden bytes read as zero inside the window
	task automatic tHidden();
		while (act !== 1'b1)
			@(posedge clk);
		rdChk(ruc_pkg::OFS_SEC, 8'h00, "secHidden");
		while (act === 1'b1)
			@(posedge clk);
		rdChk(ruc_pkg::OFS_SEC, 8'h02, "secTwo");
	endtask
	// load 23:59:59 on the first, a legal start; carry to the next day
	task automatic tCarry();
		int n;
		i_ruc_cpu_model.wr(ruc_pkg::OFS_CTRL_B, 8'h80);
		i_ruc_cpu_model.wr(ruc_pkg::OFS_CTRL_A, 8'h60);
		i_ruc_cpu_model.wr(ruc_pkg::OFS_SEC, 8'h3B);
		i_ruc_cpu_model.wr(ruc_pkg::OFS_MIN, 8'h3B);
		i_ruc_cpu_model.wr(ruc_pkg::OFS_HOUR, 8'h17);
		i_ruc_cpu_model.wr(ruc_pkg::OFS_CTRL_A, 8'h00);
		i_ruc_cpu_model.wr(ruc_pkg::OFS_CTRL_B, 8'h00);
		n = 0;
		while (act !== 1'b1)
		begin
			@(posedge clk);
			n++;
		end
		chk("halfSec", 32'h1, {31'h0, n > SEC - HALF - 5 && n < SEC - HALF + 5});
		while (act === 1'b1)
			@(posedge clk);
		rdChk(ruc_pkg::OFS_SEC, 8'h00, "sec");
		rdChk(ruc_pkg::OFS_MIN, 8'h00, "min");
		rdChk(ruc_pkg::OFS_HOUR, 8'h00, "hour");
		rdChk(ruc_pkg::OFS_DOW, 8'h02, "dow");
		rdChk(ruc_pkg::OFS_DATE, 8'h02, "date");
		chk("irqOff", 32'h0, {31'h0, irq});
		rdChk(ruc_pkg::OFS_CTRL_C, 8'h30, "flagsC");
		rdChk(ruc_pkg::OFS_CTRL_C, 8'h00, "flagsClr");
	endtask
	// standby gate drops a write and zeroes the read
	task automatic tGate();
		@(posedge clk);
		gate <= 1'b1;
		i_ruc_cpu_model.wr(ruc_pkg::OFS_SEC, 8'h2A);
		rdChk(ruc_pkg::OFS_DOW, 8'h00, "gateRd");
		gate <= 1'b0;
		rdChk(ruc_pkg::OFS_SEC, 8'h00, "gateWr");
	endtask
	// set bit written inside the pre-update delay aborts the update
	task automatic tAbort();
		int n;
		n = 0;
		while (update_in_progress_flag !== 1'b1)
			@(posedge clk);
		i_ruc_cpu_model.wr(ruc_pkg::OFS_CTRL_B, 8'h80);
		repeat (300)
		begin
			@(posedge clk);
			n = n + int'(act === 1'b1);
		end
		chk("abortWin", 32'h0, 32'(n));
		chk("abortUip", 32'h0, {31'h0, update_in_progress_flag});
		rdChk(ruc_pkg::OFS_SEC, 8'h00, "abortSec");
	endtask
	// all-wildcard alarm, then a mismatching second
	task automatic tIrq();
		i_ruc_cpu_model.wr(ruc_pkg::OFS_SEC_ALM, 8'hC0);
		i_ruc_cpu_model.wr(ruc_pkg::OFS_MIN_ALM, 8'hC0);
		i_ruc_cpu_model.wr(ruc_pkg::OFS_HOUR_ALM, 8'hC0);
		i_ruc_cpu_model.rd(ruc_pkg::OFS_CTRL_C, v);
		i_ruc_cpu_model.wr(ruc_pkg::OFS_CTRL_B, 8'h30);
		meas(UCF);
		repeat (2) @(posedge clk);
		chk("irqOn", 32'h1, {31'h0, irq});
		rdChk(ruc_pkg::OFS_CTRL_C, 8'hB0, "alarmC");
		i_ruc_cpu_model.wr(ruc_pkg::OFS_SEC_ALM, 8'h30);
		chk("irqClr", 32'h0, {31'h0, irq});
		meas(UCF);
		rdChk(ruc_pkg::OFS_CTRL_C, 8'h90, "noAlarm");
	endtask
	// periodic ticks around the progress flag, slow base window, divider held clear
	task automatic tBase();
		int n;
		n = 0;
		i_ruc_cpu_model.wr(ruc_pkg::OFS_CTRL_A, 8'h1E);
		i_ruc_cpu_model.wr(ruc_pkg::OFS_CTRL_B, 8'h70);
		while (update_in_progress_flag !== 1'b1)
			@(posedge clk);
		rdChk(ruc_pkg::OFS_CTRL_C, 8'hC0, "pfAtRise");
		rdChk(ruc_pkg::OFS_SEC, 8'h02, "secPre");
		while (act !== 1'b1)
			@(posedge clk);
		while (act === 1'b1)
			@(posedge clk);
		rdChk(ruc_pkg::OFS_CTRL_C, 8'h90, "pfQuiet");
		i_ruc_cpu_model.wr(ruc_pkg::OFS_CTRL_A, 8'h2E);
		meas(UCS);
		i_ruc_cpu_model.wr(ruc_pkg::OFS_CTRL_A, 8'h60);
		repeat (SEC + 200)
		begin
			@(posedge clk);
			n = n + int'(update_in_progress_flag === 1'b1);
		end
		chk("divClear", 32'h0, 32'(n));
	endtask
	// ==========================================================
	// main sequence and verdict
	// ==========================================================
	task automatic results();
		if (n_errors == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial
	begin
		rst = 1'b1;
		gate = 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		tFirst();
		tHidden();
		tCarry();
		tGate();
		tAbort();
		tIrq();
		tBase();
		results();
	end
endmodule
